// File: src/ptw_timer.sv
// prescaled timer, interrupt sequencing and wait-mode bus control
`timescale 1ns/1ps
`default_nettype none
module ptw_timer
	import ptw_pkg::*;
#(
	parameter int STACK_CYCLES = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic por,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic timer_pin,
	input wire logic ext_irq,
	input wire logic insn_done,
	input wire logic wait_insn,
	input wire logic stop_insn,
	input wire logic software_trap,
	input wire logic [4:0] next_insn_addr,
	output logic address_strobe,
	output logic data_strobe,
	output logic rw_read,
	output logic bus_oe,
	output logic [4:0] high_addr,
	output logic core_clk_en,
	output logic int_mask,
	output logic stacking,
	output logic vector_valid,
	output logic [15:0] vector_addr
);
	ptw_state_t state;
	logic [7:0] counter;
	logic [6:0] prescaler;
	logic [7:0] ctrl;
	logic [1:0] ctrl_hi;
	logic [5:0] ctrl_lo;
	logic [2:0] phase;
	logic pin_sync;
	logic clk_sel_d;
	logic from_wait;
	logic [3:0] stack_cnt;
	logic [15:0] pend_vec;
	logic trap_pend;
	logic acc_done;
	logic strobe;
	logic pin_gated;
	logic clk_sel;
	logic fall;
	logic tap_prev;
	logic tap;
	logic count_tick;
	logic wr_cnt;
	logic wr_ctl;
	logic wr_core;
	logic hw_pend;
	logic zero_step;

	// one divide-by-five strobe phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= 3'h0;
		end else if (phase == PTW_STROBE_LAST) begin
			phase <= 3'h0;
		end else begin
			phase <= phase + 3'h1;
		end
	end
	assign strobe = (phase < 3'h2);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_sync <= 1'b0;
		end else begin
			pin_sync <= timer_pin;
		end
	end

	assign pin_gated = pin_sync & ctrl[PTW_BIT_EXT];
	assign clk_sel = ctrl[PTW_BIT_SRC] ? pin_gated :
		(ctrl[PTW_BIT_EXT] ? (pin_gated & ~strobe) : strobe);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clk_sel_d <= 1'b0;
		end else begin
			clk_sel_d <= clk_sel;
		end
	end
	assign fall = clk_sel_d & ~clk_sel;

	function automatic logic tap_of(input logic [6:0] p,
			input logic [2:0] s);
		logic [7:0] ext;
		ext = {p, 1'b0};
		tap_of = (s == 3'h0) ? 1'b0 : ext[s];
	endfunction

	// writes land only at the edge that answers the request
	assign wr_cnt = avs_write && !avs_waitrequest &&
		(avs_address == PTW_OFF_COUNTER);
	assign wr_ctl = avs_write && !avs_waitrequest &&
		(avs_address == PTW_OFF_CONTROL);
	assign wr_core = avs_write && !avs_waitrequest &&
		(avs_address == PTW_OFF_CORE);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prescaler <= 7'h00;
			tap_prev <= 1'b0;
		end else if (wr_ctl && avs_writedata[PTW_BIT_PCLR]) begin
			prescaler <= 7'h00;
			tap_prev <= 1'b0;
		end else if (fall) begin
			prescaler <= prescaler + 7'h01;
			tap_prev <= tap_of(prescaler + 7'h01, ctrl[2:0]);
		end
	end
	assign tap = tap_of(prescaler + 7'h01, ctrl[2:0]);
	// falling edge of the chosen tap, divide-by-one takes every fall
	assign count_tick = fall && ((ctrl[2:0] == 3'h0) || (tap_prev && !tap));
	assign zero_step = count_tick && !wr_cnt && (counter == PTW_ONE);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			counter <= PTW_COUNT_POR;
		end else if (por) begin
			counter <= PTW_COUNT_POR;
		end else if (wr_cnt) begin
			counter <= avs_writedata[7:0];
		end else if (count_tick) begin
			counter <= counter - 8'h01;
		end
	end

	assign ctrl = {ctrl_hi, ctrl_lo};
	// low six bits survive external reset, only power-on reset loads them
	always_ff @(posedge clk) begin
		if (por) begin
			ctrl_lo <= PTW_CTRL_POR[5:0];
		end else if (wr_ctl) begin
			ctrl_lo <= {avs_writedata[5:4], 1'b0, avs_writedata[2:0]};
		end
	end
	// request and inhibit, zero_step request set wins over write and stop clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_hi <= PTW_CTRL_POR[7:6];
		end else if (por) begin
			ctrl_hi <= PTW_CTRL_POR[7:6];
		end else begin
			if (wr_ctl) begin
				ctrl_hi[0] <= avs_writedata[PTW_BIT_INH];
				ctrl_hi[1] <= avs_writedata[PTW_BIT_REQ];
			end
			if (stop_insn) begin
				ctrl_hi[1] <= 1'b0;
				ctrl_hi[0] <= 1'b1;
			end
			if (zero_step) begin
				ctrl_hi[1] <= 1'b1;
			end
		end
	end

	assign hw_pend = ext_irq || (ctrl[PTW_BIT_REQ] && !ctrl[PTW_BIT_INH]);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= PTW_RUN;
			int_mask <= 1'b1;
			from_wait <= 1'b0;
			stack_cnt <= 4'h0;
			pend_vec <= PTW_VEC_TIMER;
			trap_pend <= 1'b0;
			stacking <= 1'b0;
			vector_valid <= 1'b0;
			vector_addr <= 16'h0000;
			core_clk_en <= 1'b1;
		end else begin
			vector_valid <= 1'b0;
			if (wr_core) begin
				int_mask <= avs_writedata[0];
			end
			if (software_trap) begin
				trap_pend <= 1'b1;
			end
			case (state)
				PTW_RUN: begin
					if (insn_done && !int_mask && hw_pend) begin
						state <= PTW_STACK;
						stack_cnt <= 4'h0;
						stacking <= 1'b1;
						pend_vec <= ext_irq ? PTW_VEC_EXT : PTW_VEC_TIMER;
					end else if (insn_done && (trap_pend || software_trap)) begin
						state <= PTW_STACK;
						trap_pend <= 1'b0;
						stack_cnt <= 4'h0;
						stacking <= 1'b1;
						pend_vec <= PTW_VEC_TRAP;
					end else if (wait_insn) begin
						state <= PTW_WAIT;
						int_mask <= 1'b0;
						core_clk_en <= 1'b0;
					end
				end
				PTW_WAIT: begin
					if (hw_pend) begin
						core_clk_en <= 1'b1;
						stacking <= 1'b1;
						stack_cnt <= 4'h0;
						state <= PTW_STACK;
						pend_vec <= ext_irq ? PTW_VEC_EXT : PTW_VEC_TIMER_WAIT;
					end
				end
				PTW_STACK: begin
					if (stack_cnt == 4'(STACK_CYCLES - 1)) begin
						stacking <= 1'b0;
						int_mask <= 1'b1;
						state <= PTW_VECTOR;
					end else begin
						stack_cnt <= stack_cnt + 4'h1;
					end
				end
				PTW_VECTOR: begin
					vector_valid <= 1'b1;
					vector_addr <= pend_vec;
					state <= PTW_RUN;
				end
				default: begin
					state <= PTW_RUN;
				end
			endcase
		end
	end

	// bus pins, strobes and drive low, read, next_insn_addr on the high address in wait
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			address_strobe <= 1'b0;
			data_strobe <= 1'b0;
			rw_read <= 1'b1;
			bus_oe <= 1'b0;
			high_addr <= 5'h00;
		end else if (state == PTW_WAIT) begin
			address_strobe <= 1'b0;
			data_strobe <= 1'b0;
			rw_read <= 1'b1;
			bus_oe <= 1'b0;
			high_addr <= next_insn_addr;
		end else begin
			address_strobe <= strobe;
			data_strobe <= (phase >= 3'h3);
			rw_read <= 1'b1;
			bus_oe <= strobe;
			high_addr <= next_insn_addr;
		end
	end

	// avalon slave, one wait state per access
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_done <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			acc_done <= (avs_read || avs_write) && !acc_done;
			if (avs_read && !acc_done) begin
				if (avs_address == PTW_OFF_COUNTER) begin
					avs_readdata <= {24'h000000, counter};
				end else if (avs_address == PTW_OFF_CONTROL) begin
					avs_readdata <= {24'h000000, ctrl & 8'hF7};
				end else if (avs_address == PTW_OFF_CORE) begin
					avs_readdata <= {31'h0, int_mask};
				end else if (avs_address == PTW_OFF_STATUS) begin
					avs_readdata <= {30'h0, stacking, state == PTW_WAIT};
				end else begin
					avs_readdata <= 32'h0000_0000;
				end
			end
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && !acc_done);
		end
	end

	wrap_a: assert property (@(posedge clk) disable iff (rst)
		(count_tick && !wr_cnt && !por && counter == PTW_ZERO)
		|=> counter == PTW_COUNT_POR) else $error("no wrap");
	req_set_a: assert property (@(posedge clk) disable iff (rst)
		zero_step && !por |=> ctrl[PTW_BIT_REQ]) else $error("no flag");
	pclr_read_a: assert property (@(posedge clk) disable iff (rst)
		!ctrl[PTW_BIT_PCLR]) else $error("bit three set");
	wait_mask_a: assert property (@(posedge clk) disable iff (rst)
		state == PTW_WAIT && $past(state) != PTW_WAIT |->
		!int_mask) else $error("mask");
	wait_pins_a: assert property (@(posedge clk) disable iff (rst)
		state == PTW_WAIT ##1 state == PTW_WAIT |-> !address_strobe &&
		!data_strobe && rw_read && !bus_oe) else $error("pins");
	wake_clk_a: assert property (@(posedge clk) disable iff (rst)
		stacking |-> core_clk_en) else $error("clock off");
	stack_mask_a: assert property (@(posedge clk) disable iff (rst)
		state == PTW_STACK && $past(state) == PTW_STACK |-> !vector_valid)
		else $error("early vector");
	wait_vec_a: assert property (@(posedge clk) disable iff (rst)
		state == PTW_WAIT && !ext_irq && hw_pend |-> ##[1:20] vector_valid
		&& vector_addr == PTW_VEC_TIMER_WAIT) else $error("vector");
	cnt_load_a: assert property (@(posedge clk) disable iff (rst)
		wr_cnt && !por |=> counter == $past(avs_writedata[7:0]))
		else $error("counter load");
	no_extra_a: assert property (@(posedge clk) disable iff (rst)
		!count_tick && !wr_cnt && !por |=> counter == $past(counter))
		else $error("extra decrement");
	step_down_a: assert property (@(posedge clk) disable iff (rst)
		count_tick && !wr_cnt && !por && counter != PTW_ZERO
		|=> counter == $past(counter) - 8'h01) else $error("no step");
	pclr_a: assert property (@(posedge clk) disable iff (rst)
		wr_ctl && avs_writedata[PTW_BIT_PCLR] |=> prescaler == 7'h00)
		else $error("prescaler kept");
	stop_a: assert property (@(posedge clk) disable iff (rst)
		stop_insn && !zero_step && !por
		|=> !ctrl[PTW_BIT_REQ] && ctrl[PTW_BIT_INH]) else $error("stop");
	wake_a: assert property (@(posedge clk) disable iff (rst)
		state == PTW_WAIT && hw_pend |=> state == PTW_STACK &&
		core_clk_en) else $error("no wake");
	stay_wait_a: assert property (@(posedge clk) disable iff (rst)
		state == PTW_WAIT && !hw_pend |=> state == PTW_WAIT)
		else $error("left wait");
	ext_first_a: assert property (@(posedge clk) disable iff (rst)
		state == PTW_WAIT && ext_irq |=> pend_vec == PTW_VEC_EXT)
		else $error("external not first");
	vec_timer_a: assert property (@(posedge clk) disable iff (rst)
		state == PTW_RUN && insn_done && !int_mask && hw_pend && !ext_irq
		|=> pend_vec == PTW_VEC_TIMER) else $error("timer vector");
	mask_gate_a: assert property (@(posedge clk) disable iff (rst)
		state == PTW_RUN && int_mask && insn_done && !trap_pend &&
		!software_trap |=> state != PTW_STACK) else $error("masked");
	por_cnt_a: assert property (@(posedge clk) disable iff (rst)
		por |=> counter == PTW_COUNT_POR) else $error("por count");
	por_inh_a: assert property (@(posedge clk) disable iff (rst)
		por |=> ctrl[PTW_BIT_INH]) else $error("por inhibit");
endmodule
`default_nettype wire

// File: src/ptw_pkg.sv
// package for the prescaled timer with wait-mode interrupt control
package ptw_pkg;
	localparam logic [3:0] PTW_OFF_COUNTER = 4'h0;
	localparam logic [3:0] PTW_OFF_CONTROL = 4'h9;
	localparam logic [3:0] PTW_OFF_CORE = 4'h1;
	localparam logic [3:0] PTW_OFF_STATUS = 4'h2;
	localparam logic [7:0] PTW_COUNT_POR = 8'hFF;
	localparam logic [7:0] PTW_CTRL_POR = 8'h40;
	localparam int PTW_BIT_REQ = 7;
	localparam int PTW_BIT_INH = 6;
	localparam int PTW_BIT_SRC = 5;
	localparam int PTW_BIT_EXT = 4;
	localparam int PTW_BIT_PCLR = 3;
	localparam logic [15:0] PTW_VEC_TIMER = 16'h1FF8;
	localparam logic [15:0] PTW_VEC_TIMER_WAIT = 16'h1FF6;
	localparam logic [15:0] PTW_VEC_EXT = 16'h1FFA;
	localparam logic [15:0] PTW_VEC_TRAP = 16'h1FFC;
	localparam logic [2:0] PTW_STROBE_DIV = 3'h5;
	localparam logic [2:0] PTW_STROBE_LAST = 3'h4;
	localparam logic [7:0] PTW_ZERO = 8'h00;
	localparam logic [7:0] PTW_ONE = 8'h01;
	typedef enum logic [2:0] {
		PTW_RUN, PTW_WAIT, PTW_FINISH, PTW_STACK, PTW_VECTOR
	} ptw_state_t;
endpackage

// File: testbench/ptw_core_model.sv
// core-side model: instruction completion pulses and external timer pin
`timescale 1ns/1ps
`default_nettype none
module ptw_core_model #(
	parameter logic [4:0] NEXT_ADDR = 5'h15
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic core_clk_en,
	output logic insn_done,
	output logic timer_pin,
	output logic [4:0] next_insn_addr
);
	logic [2:0] phase;
	logic [3:0] pin_cnt;
	// one instruction ends every eight cycles while the core is clocked
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= 3'h0;
			insn_done <= 1'b0;
		end else begin
			phase <= core_clk_en ? phase + 3'h1 : 3'h0;
			insn_done <= core_clk_en && (phase == 3'h3);
		end
	end
	// pin levels last eight cycles, wider than one clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_cnt <= 4'h0;
		end else begin
			pin_cnt <= pin_cnt + 4'h1;
		end
	end
	assign timer_pin = pin_cnt[3];
	assign next_insn_addr = NEXT_ADDR;
endmodule
`default_nettype wire

// File: testbench/ptw_timer_tb.sv
// self-checking bench for the prescaled timer
`timescale 1ns/1ps
`default_nettype none
module ptw_timer_tb;
	import ptw_pkg::*;
	localparam logic [4:0] NXT = 5'h15;
	logic clk, rst, por, avs_read, avs_write, ext_irq;
	logic wait_insn, stop_insn, software_trap, avs_waitrequest;
	logic timer_pin, insn_done, address_strobe, data_strobe, rw_read;
	logic bus_oe, core_clk_en, int_mask, stacking, vector_valid;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [4:0] next_insn_addr, high_addr;
	logic [15:0] vector_addr;
	logic [31:0] rd_q[$];
	logic [31:0] vec_q[$];
	logic [7:0] r;
	int n_fail = 0;
	int samples_checked = 0;
	always #10 clk = ~clk;
	ptw_timer dut (.clk(clk), .rst(rst), .por(por), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .timer_pin(timer_pin),
		.ext_irq(ext_irq), .insn_done(insn_done), .wait_insn(wait_insn),
		.stop_insn(stop_insn), .software_trap(software_trap),
		.next_insn_addr(next_insn_addr), .address_strobe(address_strobe),
		.data_strobe(data_strobe), .rw_read(rw_read), .bus_oe(bus_oe),
		.high_addr(high_addr), .core_clk_en(core_clk_en),
		.int_mask(int_mask), .stacking(stacking),
		.vector_valid(vector_valid), .vector_addr(vector_addr));
	ptw_core_model #(.NEXT_ADDR(NXT)) core (.clk(clk), .rst(rst),
		.core_clk_en(core_clk_en), .insn_done(insn_done),
		.timer_pin(timer_pin), .next_insn_addr(next_insn_addr));
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		wait_insn <= (k == 0);
		stop_insn <= (k == 1);
		software_trap <= (k == 2);
		@(posedge clk);
		wait_insn <= 1'b0;
		stop_insn <= 1'b0;
		software_trap <= 1'b0;
	endtask
	task automatic drain;
		int k;
		k = 0;
		while (vec_q.size() != 0 && k < 600) begin
			@(posedge clk);
			k++;
		end
		check("pending vectors", 32'(vec_q.size()), 32'h0);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// result watcher: oldest note against each answer
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			check("readdata", avs_readdata, rd_q.pop_front());
		if (vector_valid === 1'b1)
			check("vector", {16'h0, vector_addr}, vec_q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		finish_test;
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		por = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		ext_irq = 1'b0;
		wait_insn = 1'b0;
		stop_insn = 1'b0;
		software_trap = 1'b0;
		void'($urandom(32'h0551));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(PTW_OFF_COUNTER, {24'h0, PTW_COUNT_POR});
		rd(PTW_OFF_CONTROL, {24'h0, PTW_CTRL_POR});
		por <= 1'b0;
		rd(4'hF, 32'h0);
		r = 8'($urandom());
		bus(1'b1, PTW_OFF_CONTROL, {26'h1, r[5:0] | 6'h08});
		rd(PTW_OFF_CONTROL, {26'h1, r[5:4], 1'b0, r[2:0]});
		// timer from internal strobe, divide by one, unmasked
		bus(1'b1, PTW_OFF_CONTROL, 32'h0);
		bus(1'b1, PTW_OFF_COUNTER, 32'h3);
		vec_q.push_back({16'h0, PTW_VEC_TIMER});
		bus(1'b1, PTW_OFF_CORE, 32'h0);
		drain;
		check("mask after service", {31'h0, int_mask}, 32'h1);
		rd(PTW_OFF_CONTROL, 32'h80);
		// wait mode, timer wakes the core
		bus(1'b1, PTW_OFF_CONTROL, 32'h0);
		bus(1'b1, PTW_OFF_COUNTER, 32'h8);
		vec_q.push_back({16'h0, PTW_VEC_TIMER_WAIT});
		pulse(0);
		repeat (2) @(posedge clk);
		check("clock enable", {31'h0, core_clk_en}, 32'h0);
		check("strobes", {30'h0, address_strobe, data_strobe}, 32'h0);
		check("read line", {31'h0, rw_read}, 32'h1);
		check("bus drive", {31'h0, bus_oe}, 32'h0);
		check("high address", {27'h0, high_addr}, {27'h0, NXT});
		check("mask in wait", {31'h0, int_mask}, 32'h0);
		drain;
		// software trap with the mask set
		bus(1'b1, PTW_OFF_CONTROL, 32'h40);
		vec_q.push_back({16'h0, PTW_VEC_TRAP});
		pulse(2);
		drain;
		// software sets the flag, stop clears it and sets the inhibit
		bus(1'b1, PTW_OFF_CONTROL, 32'h80);
		rd(PTW_OFF_CONTROL, 32'h80);
		pulse(1);
		rd(PTW_OFF_CONTROL, 32'h40);
		// external reset mid-run keeps the low six control bits
		bus(1'b1, PTW_OFF_CONTROL, 32'h07);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(PTW_OFF_CONTROL, 32'h47);
		rd(PTW_OFF_CORE, 32'h1);
		repeat (4) @(posedge clk);
		finish_test;
	end
endmodule
`default_nettype wire
